// >>> verilog/lbl_pkg.sv
// Constants and types shared by the ladder bit-logic executor.
package lbl_pkg;
  localparam int ADDR_W = 10;
  localparam int BIT_ADDR_W = 12;
  localparam int WORD_W = 24;
  localparam int OPC_W = 8;
  localparam logic [ADDR_W-1:0] START_ADDR = 10'h000;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3ff;
  localparam int OPC_LSB = 16;
  localparam int OPD_LSB = 0;

  localparam logic [OPC_W-1:0] OPC_NOP = 8'h00;
  localparam logic [OPC_W-1:0] OPC_END = 8'h01;
  localparam logic [OPC_W-1:0] OPC_LOAD = 8'h40;
  localparam logic [OPC_W-1:0] OPC_LOAD_INV = 8'h41;
  localparam logic [OPC_W-1:0] OPC_AND = 8'h42;
  localparam logic [OPC_W-1:0] OPC_AND_INV = 8'h43;
  localparam logic [OPC_W-1:0] OPC_OR = 8'h44;
  localparam logic [OPC_W-1:0] OPC_OR_INV = 8'h45;
  localparam logic [OPC_W-1:0] OPC_DRIVE = 8'h46;
  localparam logic [OPC_W-1:0] OPC_DRIVE_INV = 8'h47;

  localparam logic [1:0] EXTRA_NONE = 2'h0;

  typedef enum logic [2:0] {
    LBL_IDLE = 3'b000,
    LBL_SEARCH = 3'b001,
    LBL_FETCH = 3'b010,
    LBL_EXEC = 3'b011,
    LBL_SKIP = 3'b100,
    LBL_HALT = 3'b101
  } lbl_state_e;

  // Operand words that follow the instruction word at one address.
  function automatic logic [1:0] lbl_extra_words(input logic [OPC_W-1:0] op);
    lbl_extra_words = (op[7:6] == 2'h3) ? op[1:0] : EXTRA_NONE;
  endfunction
endpackage : lbl_pkg

// >>> verilog/lbl_alu.sv
// One-bit logic unit computing the next execution condition.
module lbl_alu (
  // Operation and operands
  input wire logic [lbl_pkg::OPC_W-1:0] opc_in,
  input wire logic cond_in,
  input wire logic bit_in,
  // Results
  output logic next_cond_out,
  output logic drive_val_out,
  output logic is_drive_out
);
  import lbl_pkg::*;

  wire inv = opc_in[0];
  wire opd = bit_in ^ inv;

  always_comb begin
    next_cond_out = cond_in;
    case (opc_in)
      OPC_LOAD, OPC_LOAD_INV: next_cond_out = opd; // RQ1 RQ2
      OPC_AND, OPC_AND_INV: next_cond_out = cond_in & opd; // RQ3 RQ4
      OPC_OR, OPC_OR_INV: next_cond_out = cond_in | opd; // RQ5 RQ6
      default: next_cond_out = cond_in;
    endcase
  end

  assign is_drive_out = (opc_in == OPC_DRIVE) || (opc_in == OPC_DRIVE_INV);
  assign drive_val_out = cond_in ^ inv; // RQ9 RQ10
endmodule // lbl_alu

// >>> verilog/lbl_executor.sv
// Ladder bit-logic executor: scans program memory and evaluates bit logic.
// What this block does
// RQ1: Load sets condition to operand bit.
// RQ2: Inverted load sets condition to complement.
// RQ3: Conjunction ANDs condition with operand bit.
// RQ4: Inverted conjunction ANDs with complemented bit.
// RQ5: Disjunction ORs condition with operand bit.
// RQ6: Inverted disjunction ORs with complemented bit.
// RQ7: Each bit instruction is one program line.
// RQ8: Instructions evaluate in order, chaining condition.
// RQ9: Drive writes operand bit equal to condition.
// RQ10: Inverted drive writes complement of condition.
// RQ11: Scan to first end, then restart.
// RQ12: Nothing after first end ever executes.
// RQ13: End is function code 01, no operands.
// RQ14: No end marker means no execution.
// RQ15: Loader puts no condition on end line.
// RQ16: Start at address zero, advance consecutively.
// RQ17: One address spans one to four words.
// RQ18: Reads see earlier writes in same scan.
module lbl_executor (
  // Clock, reset and enable
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // Program memory, read data valid one cycle after address
  output logic [lbl_pkg::ADDR_W-1:0] prog_addr_out,
  input wire logic [lbl_pkg::WORD_W-1:0] prog_data_in,
  // Status
  output logic running_out,
  output logic no_end_out,
  output logic scan_done_out,
  // Operand bit write port, mirrored outside
  output logic [lbl_pkg::BIT_ADDR_W-1:0] bit_addr_out,
  output logic bit_wr_out,
  output logic bit_wdata_out,
  // Operand bits from inputs, loaded at each scan start
  input wire logic [(1 << lbl_pkg::BIT_ADDR_W)-1:0] in_bits_in,
  input wire logic [(1 << lbl_pkg::BIT_ADDR_W)-1:0] in_mask_in
);
  import lbl_pkg::*;

  localparam int NBITS = 1 << BIT_ADDR_W;

  lbl_state_e state;
  lbl_state_e next_state;
  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] next_pc;
  logic [1:0] skip_cnt;
  logic srch_tail;
  logic cond;
  logic [NBITS-1:0] bits;

  wire [OPC_W-1:0] opc = prog_data_in[OPC_LSB +: OPC_W];
  wire [BIT_ADDR_W-1:0] opd = prog_data_in[OPD_LSB +: BIT_ADDR_W];
  wire is_end = (opc == OPC_END); // RQ13
  wire pc_last = (pc == LAST_ADDR);
  wire [1:0] extra = lbl_extra_words(opc);
  wire next_cond;
  wire drv_val;
  wire is_drv;
  wire exec = (state == LBL_EXEC) && clk_en_in;

  lbl_alu u_alu (
    .opc_in(opc),
    .cond_in(cond),
    .bit_in(bits[opd]),
    .next_cond_out(next_cond),
    .drive_val_out(drv_val),
    .is_drive_out(is_drv)
  );

  always_comb begin
    next_state = state;
    next_pc = pc;
    case (state)
      LBL_IDLE: begin
        next_state = LBL_SEARCH;
        next_pc = START_ADDR;
      end
      // Confirm an end marker exists before running anything.
      LBL_SEARCH: begin
        if (is_end) begin
          next_state = LBL_FETCH; // RQ14
          next_pc = START_ADDR; // RQ16
        end else if (pc_last && srch_tail) begin
          next_state = LBL_HALT; // RQ14
        end else if (!pc_last) begin
          next_pc = pc + 10'h001;
        end
        // Read data trails the address by one cycle, so the last address
        // is held for a second look before the search gives up.
      end
      LBL_FETCH: next_state = LBL_EXEC;
      LBL_EXEC: begin
        if (is_end) begin
          next_state = LBL_FETCH; // RQ11 RQ12
          next_pc = START_ADDR;
        end else if (extra != EXTRA_NONE) begin
          next_state = LBL_SKIP; // RQ17
          next_pc = pc + 10'h001;
        end else begin
          next_state = LBL_FETCH; // RQ7 RQ8 RQ16
          next_pc = pc + 10'h001;
        end
      end
      LBL_SKIP: begin
        next_pc = pc + 10'h001;
        next_state = (skip_cnt == 2'h1) ? LBL_FETCH : LBL_SKIP;
      end
      LBL_HALT: next_state = LBL_HALT;
      default: next_state = LBL_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state <= LBL_IDLE;
      pc <= START_ADDR;
      skip_cnt <= 2'h0;
      srch_tail <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      pc <= next_pc;
      srch_tail <= (state == LBL_SEARCH) && pc_last; // RQ14
      if (state == LBL_EXEC) begin
        skip_cnt <= extra;
      end else if (state == LBL_SKIP) begin
        skip_cnt <= skip_cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      cond <= 1'b0;
    end else if (exec) begin
      cond <= next_cond; // RQ8
    end
  end

  // Writes land in the image at once so later reads see them.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      bits <= '0;
    end else if (clk_en_in) begin
      if (exec && is_drv) begin
        bits[opd] <= drv_val; // RQ9 RQ10 RQ18
      end else if (state == LBL_FETCH && pc == START_ADDR) begin
        bits <= (bits & ~in_mask_in) | (in_bits_in & in_mask_in);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      bit_addr_out <= '0;
      bit_wr_out <= 1'b0;
      bit_wdata_out <= 1'b0;
      scan_done_out <= 1'b0;
    end else if (clk_en_in) begin
      bit_wr_out <= exec && is_drv;
      bit_addr_out <= opd;
      bit_wdata_out <= drv_val;
      scan_done_out <= exec && is_end; // RQ11
    end
  end

  assign prog_addr_out = pc;
  assign running_out = (state == LBL_FETCH) || (state == LBL_EXEC) ||
                       (state == LBL_SKIP);
  assign no_end_out = (state == LBL_HALT);

  sequence s_end_exec;
    exec && is_end;
  endsequence

  a_end_restart: assert property (@(posedge clock_in) // RQ11 RQ12
    disable iff (!nrst_in)
    s_end_exec |=> pc == START_ADDR && state == LBL_FETCH)
    else $error("end marker did not restart scan");
  a_no_end_halt: assert property (@(posedge clock_in) // RQ14
    disable iff (!nrst_in)
    no_end_out |-> !bit_wr_out && !running_out)
    else $error("program ran without end marker");
  a_drive_value: assert property (@(posedge clock_in) // RQ9
    disable iff (!nrst_in)
    exec && opc == OPC_DRIVE |=> bit_wr_out && bit_wdata_out == $past(cond))
    else $error("drive wrote wrong value");
  a_drive_inv: assert property (@(posedge clock_in) // RQ10
    disable iff (!nrst_in)
    exec && opc == OPC_DRIVE_INV |=>
    bit_wr_out && bit_wdata_out != $past(cond))
    else $error("inverted drive wrote wrong value");
  a_load_cond: assert property (@(posedge clock_in) // RQ1
    disable iff (!nrst_in)
    exec && opc == OPC_LOAD |=> cond == $past(bits[opd]))
    else $error("load did not copy operand");
  a_load_inv: assert property (@(posedge clock_in) // RQ2
    disable iff (!nrst_in)
    exec && opc == OPC_LOAD_INV |=> cond == !$past(bits[opd]))
    else $error("inverted load did not complement operand");
  a_and_cond: assert property (@(posedge clock_in) // RQ3
    disable iff (!nrst_in)
    exec && opc == OPC_AND |=> cond == ($past(cond) && $past(bits[opd])))
    else $error("and gave wrong condition");
  a_and_clear: assert property (@(posedge clock_in) // RQ3 RQ4
    disable iff (!nrst_in)
    exec && (opc == OPC_AND || opc == OPC_AND_INV) && !cond |=> !cond)
    else $error("and with off condition gave on");
  a_and_inv: assert property (@(posedge clock_in) // RQ4
    disable iff (!nrst_in)
    exec && opc == OPC_AND_INV |=>
    cond == ($past(cond) && !$past(bits[opd])))
    else $error("inverted and gave wrong condition");
  a_or_set: assert property (@(posedge clock_in) // RQ5 RQ6
    disable iff (!nrst_in)
    exec && (opc == OPC_OR || opc == OPC_OR_INV) && cond |=> cond)
    else $error("or with on condition gave off");
  a_or_cond: assert property (@(posedge clock_in) // RQ5
    disable iff (!nrst_in)
    exec && opc == OPC_OR |=> cond == ($past(cond) || $past(bits[opd])))
    else $error("or gave wrong condition");
  a_or_inv: assert property (@(posedge clock_in) // RQ6
    disable iff (!nrst_in)
    exec && opc == OPC_OR_INV |=>
    cond == ($past(cond) || !$past(bits[opd])))
    else $error("inverted or gave wrong condition");
  a_pc_step: assert property (@(posedge clock_in) // RQ16
    disable iff (!nrst_in)
    exec && !is_end |=> pc == $past(pc) + 10'h001)
    else $error("program address did not advance by one");
  a_skip_words: assert property (@(posedge clock_in) // RQ17
    disable iff (!nrst_in)
    exec && !is_end && extra != EXTRA_NONE |=>
    state == LBL_SKIP && skip_cnt == $past(extra))
    else $error("operand words of a long address were not skipped");
endmodule // lbl_executor

// >>> testbench/lbl_executor_tb.sv
// Self-checking bench for the ladder bit-logic executor.
module lbl_executor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lbl_pkg::*;
  logic clock_in = 0;
  logic nrst_in = 0;
  logic clk_en_in = 0;
  logic [ADDR_W-1:0] prog_addr_out;
  logic [WORD_W-1:0] prog_data_in = '0;
  logic running_out, no_end_out, scan_done_out, bit_wr_out, bit_wdata_out;
  logic [BIT_ADDR_W-1:0] bit_addr_out;
  logic [4095:0] in_bits_in = '0;
  logic [4095:0] in_mask_in = '0;
  logic [WORD_W-1:0] mem [1024];
  logic [12:0] expq [$];
  logic [12:0] e;
  logic [31:0] rs = 32'h53;
  bit img [32];
  bit cond;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int scans = 0;

  lbl_executor lbl_executor_inst (.clock_in, .nrst_in, .clk_en_in,
    .prog_addr_out, .prog_data_in, .running_out, .no_end_out,
    .scan_done_out, .bit_addr_out, .bit_wr_out, .bit_wdata_out,
    .in_bits_in, .in_mask_in);

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic print_verdict();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_wr(logic [12:0] got, logic [12:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t write %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(logic got, logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t flag %b want %b", $time, got, exp);
    end
  endtask

  // Reference scan: chains the condition and queues expected writes.
  task automatic build_scan();
    int a;
    logic [7:0] op;
    bit b;
    a = 0;
    for (int k = 0; k < 32; k++) if (in_mask_in[k]) img[k] = in_bits_in[k];
    while (a < 1024 && mem[a][23:16] != OPC_END) begin
      op = mem[a][23:16];
      b = img[mem[a][4:0]];
      case (op)
        OPC_LOAD: cond = b;
        OPC_LOAD_INV: cond = !b;
        OPC_AND: cond &= b;
        OPC_AND_INV: cond &= !b;
        OPC_OR: cond |= b;
        OPC_OR_INV: cond |= !b;
        OPC_DRIVE, OPC_DRIVE_INV: begin
          img[mem[a][4:0]] = cond ^ op[0];
          expq.push_back({cond ^ op[0], mem[a][11:0]});
        end
        default: ;
      endcase
      a += 1 + (op[7:6] == 2'h3 ? op[1:0] : 0);
    end
  endtask

  // Random program; drives target only unmasked bits 16 to 31.
  task automatic make_prog(bit with_end);
    int n;
    logic [7:0] op;
    logic [4:0] o;
    n = 1 + rnd() % 40;
    for (int a = 0; a < 1024; a++) begin
      op = 8'h40 + 8'(rnd() % 8);
      if (a == 0) op = OPC_LOAD;
      else if (rnd() % 8 == 0 && (a + 3 < n || a > n))
        op = {6'h30, 2'(1 + rnd() % 3)};
      o = 5'(rnd());
      if (op == OPC_DRIVE || op == OPC_DRIVE_INV) o[4] = 1'b1;
      mem[a] = {op, 11'h000, o};
    end
    if (with_end) mem[n] = {OPC_END, 16'h0000};
    in_bits_in <= {4064'h0, rnd()};
    in_mask_in <= 4096'hffff;
  endtask

  initial forever #2.5 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    clk_en_in <= (rnd() % 4) != 0;
    if (clk_en_in) prog_data_in <= mem[prog_addr_out];
    if (cyc > 60000) begin
      fails++;
      print_verdict();
    end
    if (nrst_in && clk_en_in) begin
      if (bit_wr_out === 1'b1) begin
        e = expq.size() > 0 ? expq.pop_front() : 13'h1fff;
        cmp_wr({bit_wdata_out, bit_addr_out}, e);
      end
      if (scan_done_out === 1'b1) begin
        cmp_flag(expq.size() == 0, 1'b1);
        scans++;
        build_scan();
      end
    end
  end

  initial begin
    @(posedge clock_in);
    for (int t = 0; t < 7; t++) begin
      nrst_in <= 1'b0;
      make_prog(t < 6);
      repeat (10) @(posedge clock_in);
      expq.delete();
      img = '{default: 0};
      cond = 0;
      scans = 0;
      if (t < 6) build_scan();
      nrst_in <= 1'b1;
      for (int i = 0; i < 3000 && scans < 4 && no_end_out !== 1'b1; i++)
        @(posedge clock_in);
      if (t < 6) cmp_flag(scans >= 4, 1'b1);
      else cmp_flag(no_end_out, 1'b1);
      if (t == 6) cmp_flag(running_out, 1'b0);
      else cmp_flag(running_out, 1'b1);
      $display("test %0d done at %0t", t, $time);
    end
    print_verdict();
  end
endmodule // lbl_executor_tb
